// ### design/psc_top.sv
// module: pll source select, keyed power register and pll lock status
//
// Functional notes
// - status bit 2 shows crystal pin level after the two-flop synchroniser
// - status bit 1 reads pll lock state
// - status bit 0 set on lock falling
// - write one clears flag, zero leaves it
// - source field picks lowpower, precision, crystal
// - pll control needs 0xaa pre, post key
// - power control needs 0x01 pre, post key
// - pll locks 2 ms after wake, plus synchroniser delay
`timescale 1ns/10ps
module psc_top #(
    parameter int LOCK_CYCLES = psc_pkg::PSC_LOCK_CYCLES
) (
    input  wire logic        i_clk,        // 100 MHz system clock
    input  wire logic        i_rst,        // sync reset, active high
    input  wire logic [31:0] i_addr,       // register byte address
    input  wire logic [31:0] i_wdata,      // write data
    input  wire logic        i_wr,         // write strobe
    input  wire logic        i_rd,         // read strobe
    input  wire logic        i_xtal_pin,   // crystal input pin level
    input  wire logic        i_pll_wake,   // pll powered up (async)
    output logic      [31:0] o_rdata,      // read data, cycle after i_rd
    output logic      [1:0]  o_pll_src,    // selected pll reference
    output logic      [7:0]  o_pow_ctrl,   // power/divider control
    output logic             o_pll_lock,   // pll locked indication
    output logic             o_irq         // level interrupt
);
    import psc_pkg::*;

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic xtal_s1;
    logic xtal_s2;
    logic wake_s1;
    logic wake_s2;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            xtal_s1 <= 1'b0;
            xtal_s2 <= 1'b0;
            wake_s1 <= 1'b0;
            wake_s2 <= 1'b0;
        end else begin
            xtal_s1 <= i_xtal_pin;
            xtal_s2 <= xtal_s1;
            wake_s1 <= i_pll_wake;
            wake_s2 <= wake_s1;
        end
    end

    // ------------------------------------------------------------
    // keyed control registers
    // ------------------------------------------------------------
    psc_key_if pll_kif ();
    psc_key_if pow_kif ();

    assign pll_kif.wr    = i_wr;
    assign pll_kif.addr  = i_addr;
    assign pll_kif.wdata = i_wdata;
    assign pow_kif.wr    = i_wr;
    assign pow_kif.addr  = i_addr;
    assign pow_kif.wdata = i_wdata;

    psc_key_guard #(
        .PRE_ADDR  (PSC_ADDR_PLL_PRE),
        .CTRL_ADDR (PSC_ADDR_PLL_CTRL),
        .POST_ADDR (PSC_ADDR_PLL_POST),
        .PRE_KEY   (PSC_KEY_PLL_PRE),
        .POST_KEY  (PSC_KEY_PLL_POST)
    ) u_pll_guard (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .bus   (pll_kif)
    );

    psc_key_guard #(
        .PRE_ADDR  (PSC_ADDR_POW_PRE),
        .CTRL_ADDR (PSC_ADDR_POW_CTRL),
        .POST_ADDR (PSC_ADDR_POW_POST),
        .PRE_KEY   (PSC_KEY_POW_PRE),
        .POST_KEY  (PSC_KEY_POW_POST)
    ) u_pow_guard (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .bus   (pow_kif)
    );

    logic [7:0] pll_source_control;
    logic [7:0] power_divider_control;

    // reserved upper bits are stored as written; software keeps them zero
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            pll_source_control    <= PSC_PLL_CTRL_RST;
            power_divider_control <= PSC_POW_CTRL_RST;
        end else begin
            if (pll_kif.commit) begin
                pll_source_control <= pll_kif.value;
            end
            if (pow_kif.commit) begin
                power_divider_control <= pow_kif.value;
            end
        end
    end

    // code 11 is reserved: keep the previous reference rather than guess
    wire [1:0] src_field = pll_source_control[1:0];
    wire       src_valid = src_field != 2'h3;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_pll_src <= PSC_SRC_LOWPWR;
        end else if (src_valid) begin
            o_pll_src <= src_field;
        end
    end

    // ------------------------------------------------------------
    // lock model: relock after wake or source change
    // ------------------------------------------------------------
    logic [31:0] lock_cnt;
    logic        pll_lock;
    logic        lock_prev;

    wire src_change = src_valid && (src_field != o_pll_src);
    wire relock     = !wake_s2 || src_change;
    wire lock_done  = lock_cnt == 32'(LOCK_CYCLES - 1);

    always_ff @(posedge i_clk) begin
        if (i_rst || relock) begin
            lock_cnt <= 32'h0;
            pll_lock <= 1'b0;
        end else if (!pll_lock) begin
            lock_cnt <= lock_cnt + 32'h1;
            if (lock_done) begin
                pll_lock <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // status, interrupt flag and mask
    // ------------------------------------------------------------
    logic       irq_flag;
    logic [7:0] irq_mask;

    wire st_wr    = i_wr && i_addr == PSC_ADDR_STATUS;
    wire mask_wr  = i_wr && i_addr == PSC_ADDR_IRQ_MASK;
    wire st_rd    = i_rd && i_addr == PSC_ADDR_STATUS;
    wire lock_fall = lock_prev && !pll_lock;
    // cleared by writing one or by reading status; a new fall wins
    wire flag_clr = (st_wr && i_wdata[PSC_BIT_IRQ]) || st_rd;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            lock_prev <= 1'b0;
            irq_flag  <= 1'b0;
            irq_mask  <= PSC_MASK_RST;
        end else begin
            lock_prev <= pll_lock;
            if (lock_fall) begin
                irq_flag <= 1'b1;
            end else if (flag_clr) begin
                irq_flag <= 1'b0;
            end
            if (mask_wr) begin
                irq_mask <= i_wdata[7:0];
            end
        end
    end

    wire [7:0] status_word = {5'h00, xtal_s2,
                              pll_lock, irq_flag};

    // ------------------------------------------------------------
    // read mux; key registers read zero, unmapped addresses too
    // ------------------------------------------------------------
    logic [31:0] rd_mux;

    always_comb begin
        rd_mux = 32'h0;
        unique case (i_addr)
            PSC_ADDR_STATUS:   rd_mux = {24'h0, status_word};
            PSC_ADDR_PLL_CTRL: rd_mux = {24'h0, pll_source_control};
            PSC_ADDR_POW_CTRL: rd_mux = {24'h0, power_divider_control};
            PSC_ADDR_IRQ_MASK: rd_mux = {24'h0, irq_mask};
            default:           rd_mux = 32'h0;
        endcase
    end

    wire next_irq = irq_flag && !lock_fall && !flag_clr ? irq_mask[0]
                  : (lock_fall && irq_mask[0]);

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_rdata    <= 32'h0;
            o_pow_ctrl <= PSC_POW_CTRL_RST;
            o_pll_lock <= 1'b0;
            o_irq      <= 1'b0;
        end else begin
            o_rdata    <= i_rd ? rd_mux : 32'h0;
            o_pow_ctrl <= power_divider_control;
            o_pll_lock <= pll_lock;
            o_irq      <= next_irq;
        end
    end
endmodule

// ### design/psc_pkg.sv
// package: register map, keys, field positions and timing for pll control
package psc_pkg;
    localparam logic [31:0] PSC_ADDR_STATUS    = 32'hffff0400;
    localparam logic [31:0] PSC_ADDR_POW_PRE   = 32'hffff0404;
    localparam logic [31:0] PSC_ADDR_POW_CTRL  = 32'hffff0408;
    localparam logic [31:0] PSC_ADDR_POW_POST  = 32'hffff040c;
    localparam logic [31:0] PSC_ADDR_PLL_PRE   = 32'hffff0410;
    localparam logic [31:0] PSC_ADDR_PLL_CTRL  = 32'hffff0414;
    localparam logic [31:0] PSC_ADDR_PLL_POST  = 32'hffff0418;
    localparam logic [31:0] PSC_ADDR_IRQ_MASK  = 32'hffff041c;

    localparam logic [31:0] PSC_KEY_PLL_PRE    = 32'h000000aa;
    localparam logic [31:0] PSC_KEY_PLL_POST   = 32'h00000055;
    localparam logic [31:0] PSC_KEY_POW_PRE    = 32'h00000001;
    localparam logic [31:0] PSC_KEY_POW_POST   = 32'h000000f4;

    localparam int          PSC_BIT_IRQ        = 0;
    localparam int          PSC_BIT_LOCK       = 1;
    localparam int          PSC_BIT_XTAL       = 2;
    localparam logic [7:0]  PSC_PLL_CTRL_RST   = 8'h00;
    localparam logic [7:0]  PSC_POW_CTRL_RST   = 8'h79;
    localparam logic [7:0]  PSC_MASK_RST       = 8'h00;

    localparam logic [1:0]  PSC_SRC_LOWPWR     = 2'h0;
    localparam logic [1:0]  PSC_SRC_PRECISION  = 2'h1;
    localparam logic [1:0]  PSC_SRC_CRYSTAL    = 2'h2;

    localparam int          PSC_CLK_MHZ        = 100;
    localparam int          PSC_LOCK_TIME_US   = 2000;
    localparam int          PSC_LOCK_CYCLES    = PSC_LOCK_TIME_US*PSC_CLK_MHZ;

    typedef enum logic [2:0] {
        PSC_KS_IDLE  = 3'b001,
        PSC_KS_ARMED = 3'b010,
        PSC_KS_HELD  = 3'b100
    } psc_key_state_t;
endpackage

// ### design/psc_key_if.sv
// interface: bus write view and commit result between top and key guards
`timescale 1ns/10ps
interface psc_key_if;
    logic        wr;      // write strobe
    logic [31:0] addr;    // write address
    logic [31:0] wdata;   // write data
    logic        commit;  // protected value to be loaded
    logic [7:0]  value;   // value to load
    modport guard (input wr, addr, wdata, output commit, value);
    modport host  (output wr, addr, wdata, input commit, value);
endinterface

// ### design/psc_key_guard.sv
// module: prewrite / control / postwrite key sequence checker
`timescale 1ns/10ps
module psc_key_guard #(
    parameter logic [31:0] PRE_ADDR  = 32'h0,
    parameter logic [31:0] CTRL_ADDR = 32'h0,
    parameter logic [31:0] POST_ADDR = 32'h0,
    parameter logic [31:0] PRE_KEY   = 32'h0,
    parameter logic [31:0] POST_KEY  = 32'h0
) (
    input  wire logic  i_clk,   // system clock
    input  wire logic  i_rst,   // sync reset, active high
    psc_key_if.guard   bus      // bus writes in, commit out
);
    import psc_pkg::*;

    psc_key_state_t state;
    psc_key_state_t next_state;
    logic [7:0]     held;

    wire pre_ok   = bus.wr && bus.addr == PRE_ADDR && bus.wdata == PRE_KEY;
    wire ctrl_wr  = bus.wr && bus.addr == CTRL_ADDR;
    wire post_ok  = bus.wr && bus.addr == POST_ADDR && bus.wdata == POST_KEY;

    // any other write breaks the sequence; idle cycles do not
    always_comb begin
        next_state = state;
        unique case (state)
            PSC_KS_IDLE:  next_state = pre_ok ? PSC_KS_ARMED : PSC_KS_IDLE;
            PSC_KS_ARMED: if (bus.wr) begin
                next_state = ctrl_wr ? PSC_KS_HELD : PSC_KS_IDLE;
            end
            PSC_KS_HELD:  if (bus.wr) begin
                next_state = PSC_KS_IDLE;
            end
            default:      next_state = PSC_KS_IDLE;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state <= PSC_KS_IDLE;
            held  <= 8'h00;
        end else begin
            state <= next_state;
            if (state == PSC_KS_ARMED && ctrl_wr) begin
                held <= bus.wdata[7:0];
            end
        end
    end

    // commit only on the correct postwrite key right after the control write
    assign bus.commit = (state == PSC_KS_HELD)
                        && post_ok;
    assign bus.value  = held;
endmodule

// ### sim/psc_sva.sv
// checker: port assertions for the pll source and status block
`timescale 1ns/10ps
module psc_sva #(
    parameter int LOCK_CYCLES = 16
) (
    input  wire logic        i_clk,      // clock
    input  wire logic        i_rst,      // reset
    input  wire logic [31:0] i_addr,     // address
    input  wire logic [31:0] i_wdata,    // write data
    input  wire logic        i_wr,       // write
    input  wire logic        i_rd,       // read
    input  wire logic        i_xtal_pin, // crystal pin
    input  wire logic        i_pll_wake, // pll awake
    input  wire logic [31:0] o_rdata,    // read data
    input  wire logic [1:0]  o_pll_src,  // source
    input  wire logic [7:0]  o_pow_ctrl, // power control
    input  wire logic        o_pll_lock, // lock
    input  wire logic        o_irq       // interrupt
);
    import psc_pkg::*;
    // ----
    // helpers
    // ----
    logic [31:0] wake_cnt;
    wire         st_rd = i_rd && i_addr == PSC_ADDR_STATUS;
    wire         st_w0 = i_wr && i_addr == PSC_ADDR_STATUS && !i_wdata[0];
    // saturating, so a long awake run cannot wrap into a false early lock
    always_ff @(posedge i_clk) begin
        if (i_rst || !i_pll_wake) begin
            wake_cnt <= 32'h0;
        end else if (wake_cnt != 32'hffffffff) begin
            wake_cnt <= wake_cnt + 32'h1;
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // ----
    // properties
    // ----
    property p_src_legal; o_pll_src != 2'h3; endproperty
    a_src_legal: assert property (p_src_legal)
        else $error("reserved source driven");
    property p_src_keyed;
        $changed(o_pll_src) |->
            $past(i_wr, 2) && $past(i_addr, 2) == PSC_ADDR_PLL_POST;
    endproperty
    a_src_keyed: assert property (p_src_keyed)
        else $error("source changed without key");
    property p_pow_keyed;
        $changed(o_pow_ctrl) |->
            $past(i_wr, 2) && $past(i_addr, 2) == PSC_ADDR_POW_POST;
    endproperty
    a_pow_keyed: assert property (p_pow_keyed)
        else $error("power changed without key");
    property p_xtal; i_xtal_pin [*4] ##0 st_rd |=> o_rdata[2]; endproperty
    a_xtal: assert property (p_xtal)
        else $error("crystal level not shown");
    property p_lock_rd; st_rd |=> o_rdata[1] == o_pll_lock; endproperty
    a_lock_rd: assert property (p_lock_rd)
        else $error("lock bit differs from lock");
    property p_nowake; !i_pll_wake [*6] |-> !o_pll_lock; endproperty
    a_nowake: assert property (p_nowake)
        else $error("locked while asleep");
    property p_lock_time; $rose(o_pll_lock) |-> wake_cnt >= LOCK_CYCLES;
    endproperty
    a_lock_time: assert property (p_lock_time)
        else $error("lock too early");
    property p_wr0_keep; o_irq && st_w0 && !$past(i_rd || i_wr) |-> ##1 o_irq;
    endproperty
    a_wr0_keep: assert property (p_wr0_keep)
        else $error("flag cleared by zero write");
    c_irq: cover property ($rose(o_irq));
    c_lock: cover property ($rose(o_pll_lock));
    c_src: cover property ($changed(o_pll_src));
endmodule
bind psc_top psc_sva #(.LOCK_CYCLES(LOCK_CYCLES)) sva_u (
    .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .i_xtal_pin(i_xtal_pin),
    .i_pll_wake(i_pll_wake), .o_rdata(o_rdata), .o_pll_src(o_pll_src),
    .o_pow_ctrl(o_pow_ctrl), .o_pll_lock(o_pll_lock), .o_irq(o_irq)
);

// ### sim/testbench.sv
// testbench: register sequences for the pll source and status block
`timescale 1ns/10ps
module testbench;
    import psc_pkg::*;
    localparam int         LC = 16;
    localparam logic [1:0] SRC [3] = '{2'h0, 2'h1, 2'h3};
    localparam logic [1:0] PIN [3] = '{2'h0, 2'h1, 2'h1};
    logic        i_clk, i_rst, i_wr, i_rd, i_xtal_pin, i_pll_wake;
    logic [31:0] i_addr, i_wdata, o_rdata;
    logic [1:0]  o_pll_src;
    logic [7:0]  o_pow_ctrl;
    logic        o_pll_lock, o_irq;
    int          bad_count, samples_checked, n;

    psc_top #(.LOCK_CYCLES(LC)) dut_u (
        .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .i_xtal_pin(i_xtal_pin),
        .i_pll_wake(i_pll_wake), .o_rdata(o_rdata), .o_pll_src(o_pll_src),
        .o_pow_ctrl(o_pow_ctrl), .o_pll_lock(o_pll_lock), .o_irq(o_irq)
    );

    always #5 i_clk = ~i_clk;
    // ----
    // tasks
    // ----
    task test_done;
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task wr(input logic [31:0] a, d);
        @(posedge i_clk);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task rd(input string nm, input logic [31:0] a, exp);
        @(posedge i_clk);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        chk(nm, o_rdata, exp);
    endtask
    task pll(input logic [31:0] pk, v, qk);
        wr(PSC_ADDR_PLL_PRE, pk);
        wr(PSC_ADDR_PLL_CTRL, v);
        wr(PSC_ADDR_PLL_POST, qk);
    endtask
    task pow(input logic [31:0] pk, v, qk);
        wr(PSC_ADDR_POW_PRE, pk);
        wr(PSC_ADDR_POW_CTRL, v);
        wr(PSC_ADDR_POW_POST, qk);
    endtask
    // bounded: a lock that never moves ends the run as a failure
    task wait_lock(input logic want);
        n = 0;
        while (o_pll_lock !== want && n < 60) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        if (n == 60) begin
            bad_count++;
            test_done;
        end
    endtask
    task settle(input int c);
        repeat (c) @(posedge i_clk);
        #1;
    endtask
    // ----
    // sequence
    // ----
    initial begin
        i_clk = 1'b0;
        i_rst = 1'b1;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_addr = 32'h0;
        i_wdata = 32'h0;
        i_xtal_pin = 1'b0;
        i_pll_wake = 1'b0;
        repeat (20) @(posedge i_clk);
        i_rst <= 1'b0;
        rd("ctrl reset", PSC_ADDR_PLL_CTRL, 32'h0);
        chk("pow reset", {24'h0, o_pow_ctrl}, 32'h79);
        rd("unmapped", 32'hffff0420, 32'h0);
        rd("key read", PSC_ADDR_PLL_PRE, 32'h0);
        wr(PSC_ADDR_IRQ_MASK, 32'h1);
        i_pll_wake <= 1'b1;
        wait_lock(1'b1);
        chk("lock time", 32'(n >= LC && n <= LC + 8), 32'h1);
        @(posedge i_clk);
        i_xtal_pin <= 1'b1;
        settle(4);
        rd("xtal high", PSC_ADDR_STATUS, 32'h6);
        @(posedge i_clk);
        i_xtal_pin <= 1'b0;
        pll(PSC_KEY_PLL_PRE, 32'h2, PSC_KEY_PLL_POST);
        settle(4);
        chk("src xtal", {30'h0, o_pll_src}, 32'h2);
        chk("irq set", {31'h0, o_irq}, 32'h1);
        wr(PSC_ADDR_STATUS, 32'h0);
        settle(2);
        chk("irq kept", {31'h0, o_irq}, 32'h1);
        wr(PSC_ADDR_STATUS, 32'h1);
        settle(2);
        chk("irq clr", {31'h0, o_irq}, 32'h0);
        wait_lock(1'b1);
        rd("relocked", PSC_ADDR_STATUS, 32'h2);
        for (int k = 0; k < 3; k++) begin
            pll(PSC_KEY_PLL_PRE, {30'h0, SRC[k]}, PSC_KEY_PLL_POST);
            rd("ctrl", PSC_ADDR_PLL_CTRL, {30'h0, SRC[k]});
            chk("src", {30'h0, o_pll_src}, {30'h0, PIN[k]});
        end
        pll(32'hab, 32'h2, PSC_KEY_PLL_POST);
        pll(PSC_KEY_PLL_PRE, 32'h2, 32'h56);
        pll(PSC_KEY_POW_PRE, 32'h2, PSC_KEY_POW_POST);
        wr(PSC_ADDR_PLL_PRE, PSC_KEY_PLL_PRE);
        wr(PSC_ADDR_IRQ_MASK, 32'h1);
        wr(PSC_ADDR_PLL_CTRL, 32'h2);
        wr(PSC_ADDR_PLL_POST, PSC_KEY_PLL_POST);
        rd("ctrl kept", PSC_ADDR_PLL_CTRL, 32'h3);
        chk("src kept", {30'h0, o_pll_src}, 32'h1);
        pow(PSC_KEY_POW_PRE, 32'h5a, PSC_KEY_POW_POST);
        pow(PSC_KEY_POW_PRE, 32'h33, PSC_KEY_PLL_POST);
        rd("pow", PSC_ADDR_POW_CTRL, 32'h5a);
        chk("pow out", {24'h0, o_pow_ctrl}, 32'h5a);
        @(posedge i_clk);
        i_pll_wake <= 1'b0;
        wait_lock(1'b0);
        settle(3);
        rd("lock lost", PSC_ADDR_STATUS, 32'h1);
        settle(2);
        chk("irq read clr", {31'h0, o_irq}, 32'h0);
        test_done;
    end
endmodule
